// [common/can_filt_pkg.sv]
// constants for the receive acceptance filter: register map, reset values, codes
// assumes an 8-bit register port and a receive engine on the same clock
package can_filt_pkg;
  localparam int NUM_FILT    = 16;
  localparam int NUM_MASK    = 2;
  localparam int LEGACY_FILT = 6;
  localparam int ID_BITS     = 29;
  localparam int DATA_BITS   = 18;
  localparam int BYTE_BITS   = 8;
  localparam int TYPE_BIT    = 3;

  // operating modes
  localparam logic [1:0] MODE_LEGACY = 2'h0;

  // register map, filter n at FILT_BASE + 4*n, mask n at MASK_BASE + 4*n
  localparam logic [7:0] FILT_BASE = 8'h00;
  localparam logic [7:0] MASK_BASE = 8'h40;
  localparam logic [7:0] EN_LO_ADR = 8'h48;
  localparam logic [7:0] EN_HI_ADR = 8'h49;
  localparam logic [7:0] LEN_ADR   = 8'h4A;
  localparam logic [7:0] BP_BASE   = 8'h50;
  localparam logic [7:0] MSEL_BASE = 8'h58;
  localparam logic [7:0] STAT_ADR  = 8'h5C;
  localparam logic [7:0] STAT_BUF  = 8'h5D;

  // byte within a filter or mask
  localparam logic [1:0] BYTE_ID_HI  = 2'h0;
  localparam logic [1:0] BYTE_ID_LO  = 2'h1;
  localparam logic [1:0] BYTE_EXT_HI = 2'h2;
  localparam logic [1:0] BYTE_EXT_LO = 2'h3;

  localparam logic [7:0] LOW_WMASK  = 8'hEB;
  localparam logic [7:0] TYPE_CLEAR = 8'hF7;

  // reset values
  localparam logic [15:0] EN_RST   = 16'h103F;
  localparam logic [63:0] BP_RST   = 64'h0000_0000_0011_1100;
  localparam logic [31:0] MSEL_RST = 32'h0000_0550;

  // mask selection codes
  localparam logic [1:0] MSEL_MASK0 = 2'h0;
  localparam logic [1:0] MSEL_MASK1 = 2'h1;
  localparam logic [1:0] MSEL_F15   = 2'h2;
  localparam logic [1:0] MSEL_NONE  = 2'h3;

  // buffer pointer codes
  localparam logic [3:0] BUF_RX0     = 4'h0;
  localparam logic [3:0] BUF_RX1     = 4'h1;
  localparam logic [3:0] BUF_RSV_MIN = 4'h8;

  // data length codes and length count limit
  localparam logic [3:0] DLC_0   = 4'h0;
  localparam logic [3:0] DLC_1   = 4'h1;
  localparam logic [3:0] DLC_2   = 4'h2;
  localparam logic [4:0] FLC_MAX = 5'h12;
endpackage

// [common/filt_cmp_if.sv]
// one filter's compare inputs and its hit result
// assumes the control side drives everything but hit
`timescale 1ns/1ps
`default_nettype none
interface filt_cmp_if;
  logic [28:0] filt_word;
  logic        filt_ext;
  logic [28:0] mask_word;
  logic        type_enf;
  logic [17:0] data_sel;
  logic [28:0] msg_id;
  logic        msg_ext;
  logic [17:0] msg_data;
  logic        hit;
  modport ctrl (output filt_word, filt_ext, mask_word, type_enf, data_sel,
                output msg_id, msg_ext, msg_data, input hit);
  modport cmp  (input filt_word, filt_ext, mask_word, type_enf, data_sel,
                input msg_id, msg_ext, msg_data, output hit);
endinterface
`default_nettype wire

// [hdl/filt_match.sv]
// single acceptance filter compare, purely combinational
// assumes identifier words packed with the 11 standard bits at the top
`timescale 1ns/1ps
`default_nettype none
module filt_match (
  filt_cmp_if.cmp fc  // compare inputs and hit
);
  logic [28:0] care;
  logic [28:0] msg;
  logic        type_ok;

  // standard frames use the lower 18 filter bits against leading data bits
  always_comb begin
    if (fc.msg_ext) begin
      care = fc.mask_word;
      msg  = fc.msg_id;
    end else begin
      care = fc.mask_word & {11'h7FF, fc.data_sel};
      msg  = {fc.msg_id[28:18], fc.msg_data};
    end
  end

  // frame type must agree only where the type is enforced
  assign type_ok = !fc.type_enf || (fc.filt_ext == fc.msg_ext);
  // mask one means bit must equal, zero means don't care
  assign fc.hit  = type_ok && ((care & (fc.filt_word ^ msg)) == 29'h0000_0000);
endmodule
`default_nettype wire

// [hdl/can_accept_filter.sv]
// receive acceptance filters and masks with register port and match result
// assumes op_mode and cfg_mode come from controller logic on clk_sys
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module can_accept_filter (
  input  wire logic        clk_sys,       // controller clock
  input  wire logic        rst,           // synchronous reset, high
  input  wire logic [1:0]  op_mode,       // 0 legacy, 1 enhanced, 2 fifo
  input  wire logic        cfg_mode,      // controller in configuration mode
  input  wire logic [7:0]  reg_addr,      // register address
  input  wire logic [7:0]  reg_wdata,     // register write data
  input  wire logic        reg_wr,        // write strobe
  input  wire logic        reg_rd,        // read strobe
  output logic      [7:0]  reg_rdata,     // read data, cycle after strobe
  input  wire logic        frame_valid,   // decoded frame pulse
  input  wire logic        frame_ext,     // frame has extended identifier
  input  wire logic [28:0] frame_id,      // identifier, standard in [28:18]
  input  wire logic [3:0]  frame_dlc,     // data length code
  input  wire logic [17:0] frame_data,    // leading data bits
  output logic             accept_valid,  // result pulse
  output logic             accept_hit,    // frame accepted
  output logic      [3:0]  accept_filter, // winning filter
  output logic      [3:0]  accept_buffer  // buffer of winning filter
);
  localparam int NF = can_filt_pkg::NUM_FILT;
  localparam int NM = can_filt_pkg::NUM_MASK;
  localparam int DB = can_filt_pkg::DATA_BITS;
  localparam int TB = can_filt_pkg::TYPE_BIT;

  typedef struct packed {
    logic [NF-1:0][7:0] f_hi;
    logic [NF-1:0][7:0] f_lo;
    logic [NF-1:0][7:0] f_eh;
    logic [NF-1:0][7:0] f_el;
    logic [NM-1:0][7:0] m_hi;
    logic [NM-1:0][7:0] m_lo;
    logic [NM-1:0][7:0] m_eh;
    logic [NM-1:0][7:0] m_el;
    logic [NF-1:0]      en;
    logic [4:0]         flc;
    logic [NF-1:0][3:0] bp;
    logic [NF-1:0][1:0] msel;
    logic [7:0]         rdata;
    logic               res_valid;
    logic               res_hit;
    logic [3:0]         res_filt;
    logic [3:0]         res_buf;
  } state_t;

  localparam state_t ST_RST = '{en:   can_filt_pkg::EN_RST,
                                bp:   can_filt_pkg::BP_RST,
                                msel: can_filt_pkg::MSEL_RST,
                                default: '0};

  state_t s_q;
  state_t s_d;

  logic               m0;
  logic               filt_sel;
  logic               filt_ok;
  logic [3:0]         fidx;
  logic               mask_sel;
  logic               midx;
  logic               bp_sel;
  logic               ms_sel;
  logic [7:0]         rd_val;
  logic [4:0]         cnt;
  logic [17:0]        data_sel;
  logic [NF-1:0]      active;
  logic [NF-1:0]      hit_vec;
  logic [NF-1:0][3:0] buf_vec;
  logic [NM-1:0][28:0] mword;
  logic               win_hit;
  logic [3:0]         win_idx;

  // pack the four bytes into one identifier word, standard bits on top
  function automatic logic [28:0] pack_word(input logic [7:0] hi, input logic [7:0] lo,
                                            input logic [7:0] eh, input logic [7:0] el);
    pack_word = {hi, lo[7:5], lo[1:0], eh, el};
  endfunction

  // address decode
  assign m0       = (op_mode == can_filt_pkg::MODE_LEGACY);
  assign filt_sel = (reg_addr < can_filt_pkg::MASK_BASE);
  assign fidx     = reg_addr[5:2];
  assign filt_ok  = !m0 || (fidx < 4'(can_filt_pkg::LEGACY_FILT));
  assign mask_sel = (reg_addr[7:3] == can_filt_pkg::MASK_BASE[7:3]);
  assign midx     = reg_addr[2];
  assign bp_sel   = (reg_addr[7:3] == can_filt_pkg::BP_BASE[7:3]);
  assign ms_sel   = (reg_addr[7:2] == can_filt_pkg::MSEL_BASE[7:2]);

  // read mux; absent registers and unmapped addresses read zero
  always_comb begin
    rd_val = 8'h00;
    if (filt_sel) begin
      if (filt_ok) begin
        case (reg_addr[1:0])
          can_filt_pkg::BYTE_ID_HI:  rd_val = s_q.f_hi[fidx];
          can_filt_pkg::BYTE_ID_LO:  rd_val = s_q.f_lo[fidx];
          can_filt_pkg::BYTE_EXT_HI: rd_val = s_q.f_eh[fidx];
          default:                   rd_val = s_q.f_el[fidx];
        endcase
      end
    end else if (mask_sel) begin
      case (reg_addr[1:0])
        can_filt_pkg::BYTE_ID_HI:  rd_val = s_q.m_hi[midx];
        can_filt_pkg::BYTE_ID_LO: begin
          rd_val = s_q.m_lo[midx];
          if (m0) begin
            rd_val = rd_val & can_filt_pkg::TYPE_CLEAR;
          end
        end
        can_filt_pkg::BYTE_EXT_HI: rd_val = s_q.m_eh[midx];
        default:                   rd_val = s_q.m_el[midx];
      endcase
    end else if (!m0) begin
      // enhanced-only registers
      if (reg_addr == can_filt_pkg::EN_LO_ADR) begin
        rd_val = s_q.en[7:0];
      end else if (reg_addr == can_filt_pkg::EN_HI_ADR) begin
        rd_val = s_q.en[15:8];
      end else if (reg_addr == can_filt_pkg::LEN_ADR) begin
        rd_val = {3'h0, s_q.flc};
      end else if (bp_sel) begin
        rd_val = {s_q.bp[{reg_addr[2:0], 1'b1}], s_q.bp[{reg_addr[2:0], 1'b0}]};
      end else if (ms_sel) begin
        for (int k = 0; k < 4; k++) begin
          rd_val[2*k +: 2] = s_q.msel[{reg_addr[1:0], 2'(k)}];
        end
      end
    end
    // status shows the last result in every mode
    if (reg_addr == can_filt_pkg::STAT_ADR) begin
      rd_val = {s_q.res_hit, 3'h0, s_q.res_filt};
    end else if (reg_addr == can_filt_pkg::STAT_BUF) begin
      rd_val = {4'h0, s_q.res_buf};
    end
  end

  // data bits compared: legacy none, else limited by dlc and count
  always_comb begin
    cnt = 5'h00;
    if (!m0) begin
      case (frame_dlc)
        can_filt_pkg::DLC_0: cnt = 5'h00;
        can_filt_pkg::DLC_1: cnt = {2'h0, s_q.flc[2:0]};
        can_filt_pkg::DLC_2: cnt = {1'h0, s_q.flc[3:0]};
        default: begin
          // longer frames carry all 18 leading bits
          if (s_q.flc > can_filt_pkg::FLC_MAX) begin
            cnt = can_filt_pkg::FLC_MAX;
          end else begin
            cnt = s_q.flc;
          end
        end
      endcase
    end
  end

  // a data bit is compared when its position in the data stream is below cnt
  for (genvar p = 0; p < DB; p++) begin : g_dsel
    localparam int BASE = (p / can_filt_pkg::BYTE_BITS) * can_filt_pkg::BYTE_BITS;
    localparam int TOP  = (BASE + can_filt_pkg::BYTE_BITS - 1 > DB - 1) ?
                          DB - 1 : BASE + can_filt_pkg::BYTE_BITS - 1;
    localparam int LEAD = BASE + TOP - p;
    assign data_sel[p] = (5'(LEAD) < cnt);
  end

  // both masks as identifier words
  for (genvar m = 0; m < NM; m++) begin : g_mask
    assign mword[m] = pack_word(s_q.m_hi[m], s_q.m_lo[m], s_q.m_eh[m], s_q.m_el[m]);
  end

  // per filter: choose mask, type rule, buffer and participation
  for (genvar g = 0; g < NF; g++) begin : g_filt
    localparam logic [1:0] LEG_MSEL = (g < 2) ? can_filt_pkg::MSEL_MASK0
                                              : can_filt_pkg::MSEL_MASK1;
    localparam logic [3:0] LEG_BUF  = (g < 2) ? can_filt_pkg::BUF_RX0 : can_filt_pkg::BUF_RX1;
    filt_cmp_if fc ();
    logic [1:0] sel;

    assign sel = m0 ? LEG_MSEL : s_q.msel[g];
    assign fc.filt_word = pack_word(s_q.f_hi[g], s_q.f_lo[g], s_q.f_eh[g], s_q.f_el[g]);
    assign fc.filt_ext  = s_q.f_lo[g][TB];
    assign fc.data_sel  = data_sel;
    assign fc.msg_id    = frame_id;
    assign fc.msg_ext   = frame_ext;
    assign fc.msg_data  = frame_data;

    // mask word and type enforcement by selection
    always_comb begin
      case (sel)
        can_filt_pkg::MSEL_MASK0: begin
          fc.mask_word = mword[0];
          fc.type_enf  = m0 || s_q.m_lo[0][TB];
        end
        can_filt_pkg::MSEL_MASK1: begin
          fc.mask_word = mword[1];
          fc.type_enf  = m0 || s_q.m_lo[1][TB];
        end
        can_filt_pkg::MSEL_F15: begin
          fc.mask_word = pack_word(s_q.f_hi[NF-1], s_q.f_lo[NF-1],
                                   s_q.f_eh[NF-1], s_q.f_el[NF-1]);
          fc.type_enf  = s_q.f_lo[NF-1][TB];
        end
        default: begin
          // no mask: every bit and the type must agree
          fc.mask_word = 29'h1FFF_FFFF;
          fc.type_enf  = 1'b1;
        end
      endcase
    end

    // legacy: filters 0-5 always on; else enable bit and a valid pointer
    assign active[g]  = m0 ? (g < can_filt_pkg::LEGACY_FILT)
                           : (s_q.en[g] && (s_q.bp[g] < can_filt_pkg::BUF_RSV_MIN));
    assign buf_vec[g] = m0 ? LEG_BUF : s_q.bp[g];
    assign hit_vec[g] = fc.hit && active[g];

    filt_match u_match (
      .fc (fc.cmp)
    );
  end

  // lowest numbered hit wins
  always_comb begin
    win_hit = 1'b0;
    win_idx = 4'h0;
    for (int i = NF - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        win_hit = 1'b1;
        win_idx = 4'(i);
      end
    end
  end

  // next state: result capture and register writes
  always_comb begin
    s_d           = s_q;
    s_d.rdata     = reg_rd ? rd_val : 8'h00;
    s_d.res_valid = frame_valid;
    if (frame_valid) begin
      s_d.res_hit  = win_hit;
      s_d.res_filt = win_idx;
      s_d.res_buf  = buf_vec[win_idx];
    end
    if (reg_wr) begin
      if (filt_sel && filt_ok) begin
        case (reg_addr[1:0])
          can_filt_pkg::BYTE_ID_HI:  s_d.f_hi[fidx] = reg_wdata;
          can_filt_pkg::BYTE_ID_LO:  s_d.f_lo[fidx] = reg_wdata & can_filt_pkg::LOW_WMASK;
          can_filt_pkg::BYTE_EXT_HI: s_d.f_eh[fidx] = reg_wdata;
          default:                   s_d.f_el[fidx] = reg_wdata;
        endcase
      end else if (mask_sel) begin
        case (reg_addr[1:0])
          can_filt_pkg::BYTE_ID_HI:  s_d.m_hi[midx] = reg_wdata;
          can_filt_pkg::BYTE_ID_LO: begin
            s_d.m_lo[midx] = reg_wdata & can_filt_pkg::LOW_WMASK;
            if (m0) begin
              // type mask bit does not exist in legacy mode
              s_d.m_lo[midx][TB] = s_q.m_lo[midx][TB];
            end
          end
          can_filt_pkg::BYTE_EXT_HI: s_d.m_eh[midx] = reg_wdata;
          default:                   s_d.m_el[midx] = reg_wdata;
        endcase
      end else if (!m0) begin
        if (reg_addr == can_filt_pkg::EN_LO_ADR) begin
          s_d.en[7:0] = reg_wdata;
        end else if (reg_addr == can_filt_pkg::EN_HI_ADR) begin
          s_d.en[15:8] = reg_wdata;
        end else if (cfg_mode) begin
          if (reg_addr == can_filt_pkg::LEN_ADR) begin
            s_d.flc = reg_wdata[4:0];
          end else if (bp_sel) begin
            s_d.bp[{reg_addr[2:0], 1'b0}] = reg_wdata[3:0];
            s_d.bp[{reg_addr[2:0], 1'b1}] = reg_wdata[7:4];
          end else if (ms_sel) begin
            for (int k = 0; k < 4; k++) begin
              s_d.msel[{reg_addr[1:0], 2'(k)}] = reg_wdata[2*k +: 2];
            end
          end
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata     = s_q.rdata;
  assign accept_valid  = s_q.res_valid;
  assign accept_hit    = s_q.res_hit;
  assign accept_filter = s_q.res_filt;
  assign accept_buffer = s_q.res_buf;

  // result follows each frame by exactly one cycle
  property p_latency;
    @(posedge clk_sys) disable iff (rst)
    frame_valid |=> accept_valid;
  endproperty
  a_latency: assert property (p_latency) else $error("no result after frame");

  property p_only_after_frame;
    @(posedge clk_sys) disable iff (rst)
    accept_valid |-> $past(frame_valid);
  endproperty
  a_only_after_frame: assert property (p_only_after_frame) else $error("stray result");

  property p_legacy_range;
    @(posedge clk_sys) disable iff (rst)
    frame_valid && m0 |=> !accept_hit || (accept_filter < 4'h6);
  endproperty
  a_legacy_range: assert property (p_legacy_range) else $error("high filter in legacy");

  property p_all_disabled;
    @(posedge clk_sys) disable iff (rst)
    frame_valid && !m0 && (s_q.en == 16'h0000) |=> !accept_hit;
  endproperty
  a_all_disabled: assert property (p_all_disabled) else $error("hit with no filter on");

  property p_len_legacy_read;
    @(posedge clk_sys) disable iff (rst)
    reg_rd && m0 && (reg_addr == can_filt_pkg::LEN_ADR) |=> reg_rdata == 8'h00;
  endproperty
  a_len_legacy_read: assert property (p_len_legacy_read) else $error("length not zero");

  property p_len_cfg_gate;
    @(posedge clk_sys) disable iff (rst)
    reg_wr && !cfg_mode && (reg_addr == can_filt_pkg::LEN_ADR) |=> $stable(s_q.flc);
  endproperty
  a_len_cfg_gate: assert property (p_len_cfg_gate) else $error("length written outside config");

  property p_mask_type_read;
    @(posedge clk_sys) disable iff (rst)
    reg_rd && m0 && mask_sel && (reg_addr[1:0] == can_filt_pkg::BYTE_ID_LO)
      |=> !reg_rdata[TB];
  endproperty
  a_mask_type_read: assert property (p_mask_type_read) else $error("mask type bit visible");

  property p_dlc0;
    @(posedge clk_sys) disable iff (rst)
    frame_dlc == can_filt_pkg::DLC_0 |-> data_sel == 18'h0_0000;
  endproperty
  a_dlc0: assert property (p_dlc0) else $error("data compared at dlc 0");

  property p_dlc1;
    @(posedge clk_sys) disable iff (rst)
    frame_dlc == can_filt_pkg::DLC_1 |-> data_sel[17:8] == 10'h000;
  endproperty
  a_dlc1: assert property (p_dlc1) else $error("over 8 data bits at dlc 1");
endmodule
`default_nettype wire

// [tb/rx_engine_model.sv]
// receive engine stand-in: hands decoded frames to the filter block
// assumes the bench calls send right after a rising edge of clk_sys
`timescale 1ns/1ps
`default_nettype none
module rx_engine_model (
  input  wire logic        clk_sys,     // controller clock
  output logic             frame_valid, // frame pulse
  output logic             frame_ext,   // extended identifier
  output logic      [28:0] frame_id,    // identifier
  output logic      [3:0]  frame_dlc,   // data length code
  output logic      [17:0] frame_data   // leading data bits
);
  logic busy = 1'b0;

  initial begin
    frame_valid = 1'b0;
    frame_ext = 1'b0;
    frame_id = '0;
    frame_dlc = '0;
    frame_data = '0;
  end

  // fields mean nothing between frames, so keep them moving
  always @(negedge clk_sys) begin
    if (!busy) begin
      frame_ext <= ~frame_ext;
      frame_id <= ~frame_id;
      frame_dlc <= ~frame_dlc;
      frame_data <= ~frame_data;
    end
  end

  // one frame for one cycle, then a gap of gap cycles
  task automatic send(input logic e, input logic [28:0] id, input logic [3:0] dlc,
                      input logic [17:0] dat, input int gap);
    busy = 1'b1;
    frame_valid <= 1'b1;
    frame_ext <= e;
    frame_id <= id;
    frame_dlc <= dlc;
    frame_data <= dat;
    @(posedge clk_sys);
    frame_valid <= 1'b0;
    repeat (gap) @(posedge clk_sys);
    busy = 1'b0;
  endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the acceptance filter block
// assumes rx_engine_model on the frame side, bench as register master
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_sys;
  logic        rst;
  logic [1:0]  op_mode;
  logic        cfg_mode;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        frame_valid;
  logic        frame_ext;
  logic [28:0] frame_id;
  logic [3:0]  frame_dlc;
  logic [17:0] frame_data;
  logic        accept_valid;
  logic        accept_hit;
  logic [3:0]  accept_filter;
  logic [3:0]  accept_buffer;
  logic        rd_d = 1'b0;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          j;
  int          eff;
  logic [7:0]  rq[$];
  logic [8:0]  fq[$];
  logic [28:0] x;
  logic [17:0] d;
  logic [10:0] s;
  logic [4:0]  len;
  logic [3:0]  dlc;

  can_accept_filter dut_u (.clk_sys, .rst, .op_mode, .cfg_mode, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .frame_valid, .frame_ext, .frame_id, .frame_dlc,
    .frame_data, .accept_valid, .accept_hit, .accept_filter, .accept_buffer);
  rx_engine_model eng_u (.clk_sys, .frame_valid, .frame_ext, .frame_id, .frame_dlc,
    .frame_data);

  // 200 MHz
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cmp_rd(input logic [7:0] e);
    samples_checked++;
    if (reg_rdata !== e) begin
      bad_count++;
      $display("BAD reg_rdata expected %h seen %h", e, reg_rdata);
    end
  endtask

  // filter and buffer only mean something on a hit
  task automatic cmp_acc(input logic [8:0] e);
    samples_checked++;
    if (accept_hit !== e[8] || (e[8] && {accept_filter, accept_buffer} !== e[7:0])) begin
      bad_count++;
      $display("BAD accept expected %h seen %h", e, {accept_hit, accept_filter, accept_buffer});
    end
  endtask

  // strobes drop one edge before the next access so no signal is set twice at once
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask

  // four bytes of a filter or mask from one packed identifier word
  task automatic wid(input logic [7:0] b, input logic [28:0] w, input logic e);
    wr(b, w[28:21]);
    wr(b + 8'h01, {w[20:18], 1'b0, e, 1'b0, w[17:16]});
    wr(b + 8'h02, w[15:8]);
    wr(b + 8'h03, w[7:0]);
  endtask

  task automatic fr(input logic e, input logic [28:0] id, input logic [3:0] dl,
                    input logic [17:0] dat, input logic h, input logic [3:0] f);
    fq.push_back({h, f, 4'h0});
    eng_u.send(e, id, dl, dat, $urandom_range(1, 3));
  endtask

  // results come off the queues oldest first; cycle ceiling cuts a hang
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    rd_d <= reg_rd;
    if (rd_d) begin
      cmp_rd(rq.pop_front());
    end
    if (accept_valid === 1'b1) begin
      cmp_acc(fq.pop_front());
    end
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  initial begin
    j = $urandom(52617);
    rst = 1'b1;
    op_mode = 2'h1;
    cfg_mode = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(can_filt_pkg::EN_LO_ADR, 8'h3F);
    rd(can_filt_pkg::EN_HI_ADR, 8'h10);
    rd(can_filt_pkg::LEN_ADR, 8'h00);
    rd(can_filt_pkg::MASK_BASE + 8'h01, 8'h00);
    rd(can_filt_pkg::BP_BASE + 8'h01, 8'h11);
    rd(can_filt_pkg::MSEL_BASE, 8'h50);
    rd(8'h7F, 8'h00);
    fr(1'b1, 29'($urandom), 4'h0, 18'h0, 1'b1, 4'h0);
    // legacy: zeroed filters are standard type, mask type bit ignored
    op_mode <= can_filt_pkg::MODE_LEGACY;
    @(posedge clk_sys);
    fr(1'b1, 29'($urandom), 4'h0, 18'h0, 1'b0, 4'h0);
    fr(1'b0, 29'($urandom), 4'h0, 18'h0, 1'b1, 4'h0);
    rd(can_filt_pkg::EN_LO_ADR, 8'h00);
    op_mode <= 2'h2;
    cfg_mode <= 1'b0;
    wr(can_filt_pkg::LEN_ADR, 8'h05);
    rd(can_filt_pkg::LEN_ADR, 8'h00);
    cfg_mode <= 1'b1;
    wr(can_filt_pkg::LEN_ADR, 8'h12);
    rd(can_filt_pkg::LEN_ADR, 8'h12);
    // full mask with type enforced, only filter 0 on
    wr(can_filt_pkg::EN_LO_ADR, 8'h01);
    wr(can_filt_pkg::EN_HI_ADR, 8'h00);
    wid(can_filt_pkg::MASK_BASE, 29'h1FFFFFFF, 1'b1);
    rd(can_filt_pkg::MASK_BASE + 8'h01, 8'hEB);
    for (int i = 0; i < 6; i++) begin
      x = 29'($urandom);
      wid(can_filt_pkg::FILT_BASE, x, i[0]);
      fr(i[0], i[0] ? x : {x[28:18], 18'($urandom)}, 4'h0, 18'h0, 1'b1, 4'h0);
      fr(i[0], x ^ (29'h1 << $urandom_range(28, i[0] ? 0 : 18)), 4'h0, 18'h0, 1'b0, 4'h0);
      fr(!i[0], x, 4'h0, 18'h0, 1'b0, 4'h0);
    end
    // one-bit mismatch under each mask selection, a hit through mask 1 and filter 15
    for (j = 0; j < 4; j++) begin
      wr(can_filt_pkg::MSEL_BASE, 8'(j));
      fr(1'b1, x ^ 29'h1, 4'h0, 18'h0, j == 1 || j == 2, 4'h0);
    end
    wr(can_filt_pkg::MSEL_BASE, 8'h00);
    wr(can_filt_pkg::BP_BASE, 8'h07);
    fq.push_back({1'b1, 4'h0, 4'h7});
    eng_u.send(1'b1, x, 4'h0, 18'h0, 1);
    wr(can_filt_pkg::BP_BASE, 8'h08);
    fr(1'b1, x, 4'h0, 18'h0, 1'b0, 4'h0);
    wr(can_filt_pkg::BP_BASE, 8'h00);
    // data compare: a flipped byte misses only if the count reaches into it
    s = 11'($urandom);
    d = 18'($urandom);
    wid(can_filt_pkg::FILT_BASE, {s, d}, 1'b0);
    for (int i = 0; i < 16; i++) begin
      len = 5'($urandom);
      dlc = 4'($urandom_range(0, 8));
      j = $urandom_range(0, 2);
      wr(can_filt_pkg::LEN_ADR, {3'h0, len});
      case (dlc)
        4'h0: eff = 0;
        4'h1: eff = len[2:0];
        4'h2: eff = len[3:0];
        default: eff = (len > 5'd18) ? 18 : len;
      endcase
      fr(1'b0, {s, 18'($urandom)}, dlc, d ^ (18'hFF << (8 * j)), eff <= 8 * j, 4'h0);
    end
    // filter 12 only exists outside legacy mode
    x = 29'($urandom);
    wid(can_filt_pkg::FILT_BASE + 8'h30, x, 1'b1);
    wr(can_filt_pkg::EN_LO_ADR, 8'h00);
    fr(1'b1, x, 4'h0, 18'h0, 1'b0, 4'h0);
    wr(can_filt_pkg::EN_HI_ADR, 8'h10);
    fr(1'b1, x, 4'h0, 18'h0, 1'b1, 4'hC);
    rd(can_filt_pkg::STAT_ADR, 8'h8C);
    rd(can_filt_pkg::STAT_BUF, 8'h00);
    op_mode <= can_filt_pkg::MODE_LEGACY;
    @(posedge clk_sys);
    fr(1'b1, x, 4'h0, 18'h0, 1'b0, 4'h0);
    fr(1'b0, {s, 18'h0}, 4'h3, ~d, 1'b1, 4'h0);
    // misses filter 0 and zeroed filter 1, so filter 2 wins on buffer 1
    fq.push_back({1'b1, 4'h2, 4'h1});
    eng_u.send(1'b0, {~s[10:1], 1'b1, 18'h0}, 4'h0, 18'h0, 1);
    rd(can_filt_pkg::MASK_BASE + 8'h01, 8'hE3);
    // let the checker take the last read before the verdict
    repeat (2) @(posedge clk_sys);
    wrap_up();
  end
endmodule
`default_nettype wire
